// [hdl/fesro_top.sv]
// Design decisions made here: register access over Avalon-MM and the register offsets.
`include "fesro_cfg.svh"
`default_nettype none
module fesro_top
   import fesro_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [23:0] cpu_addr,
   output logic [23:0] flash_addr,
   output logic overlay_hit,
   output logic [3:0] erase_target,
   output logic [23:0] erase_base,
   output logic program_mode,
   output logic erase_mode,
   output logic block_protect
);
   // ****************************************
   // Reset release
   // ****************************************
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   logic rst_core_n;
   assign rst_core_n = rst_s2_q;

   // ****************************************
   // Bus slave
   // ****************************************
   fesro_bus_st_t st_q;
   fesro_bus_st_t st_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] ovl_q;
   logic [7:0] ovl_d;
   logic wr_take;
   logic [7:0] wbyte;
   fesro_sel_if lo_if();
   fesro_sel_if hi_if();

   assign wbyte = avs_writedata[7:0];
   assign wr_take = avs_write && (st_q == FESRO_ACK);

   always_comb begin
      st_d = st_q;
      rdata_d = rdata_q;
      case (st_q)
         FESRO_IDLE: begin
            if (avs_read || avs_write) begin
               st_d = FESRO_ACK;
               case (avs_address)
                  `FESRO_OFS_CTRL: rdata_d = {24'h0, ctrl_q};
                  `FESRO_OFS_SEL_LO: rdata_d = {24'h0, lo_if.value};
                  `FESRO_OFS_SEL_HI: rdata_d = {24'h0, hi_if.value};
                  `FESRO_OFS_OVL: rdata_d = {24'h0, ovl_q};
                  default: rdata_d = 32'h0;
               endcase
            end
         end
         FESRO_ACK: st_d = FESRO_IDLE;
         default: st_d = FESRO_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         st_q <= FESRO_IDLE;
         rdata_q <= 32'h0;
      end else begin
         st_q <= st_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (st_q != FESRO_ACK);
   assign avs_readdata = rdata_q;

   // ****************************************
   // Control and overlay registers
   // ****************************************
   always_comb begin
      ctrl_d = ctrl_q;
      ovl_d = ovl_q;
      if (wr_take && avs_address == `FESRO_OFS_CTRL) begin
         ctrl_d = wbyte & `FESRO_CTRL_MASK;
      end
      if (!ctrl_d[`FESRO_CTRL_WR_ENABLE]) begin
         ctrl_d = `FESRO_RST_BYTE;
      end
      if (wr_take && avs_address == `FESRO_OFS_OVL) begin
         ovl_d = wbyte & `FESRO_OVL_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         ctrl_q <= `FESRO_RST_BYTE;
         ovl_q <= `FESRO_RST_BYTE;
      end else begin
         ctrl_q <= ctrl_d;
         ovl_q <= ovl_d;
      end
   end

   // ****************************************
   // Erase block selects
   // ****************************************
   assign lo_if.wr = wr_take && avs_address == `FESRO_OFS_SEL_LO;
   assign lo_if.wdata = wbyte;
   assign lo_if.software_write_enable = ctrl_q[`FESRO_CTRL_WR_ENABLE];
   assign hi_if.wr = wr_take && avs_address == `FESRO_OFS_SEL_HI;
   assign hi_if.wdata = wbyte;
   assign hi_if.software_write_enable = ctrl_q[`FESRO_CTRL_WR_ENABLE];

   fesro_sel_reg #(.MASK(8'hff)) u_sel_lo (
      .clk(core_clk),
      .rst_n(rst_core_n),
      .sel(lo_if)
   );
   fesro_sel_reg #(.MASK(`FESRO_HI_MASK)) u_sel_hi (
      .clk(core_clk),
      .rst_n(rst_core_n),
      .sel(hi_if)
   );

   // ****************************************
   // Erase target decode
   // ****************************************
   logic [3:0] tgt;
   logic [23:0] base;
   always_comb begin
      tgt = `FESRO_NO_BLOCK;
      base = `FESRO_SMALL_BASE;
      for (int i = 0; i < 4; i++) begin
         if (lo_if.value[i]) begin
            tgt = 4'(i);
            base = 24'(`FESRO_SMALL_BASE + 24'(i) * `FESRO_SMALL_STEP);
         end
      end
      if (lo_if.value[4]) begin
         tgt = 4'h4;
         base = `FESRO_BLK4_BASE;
      end
      if (lo_if.value[5]) begin
         tgt = 4'h5;
         base = `FESRO_BLK5_BASE;
      end
      if (lo_if.value[6]) begin
         tgt = 4'h6;
         base = `FESRO_BLK6_BASE;
      end
      if (lo_if.value[7]) begin
         tgt = 4'h7;
         base = `FESRO_BLK7_BASE;
      end
      if (hi_if.value[0]) begin
         tgt = 4'h8;
         base = `FESRO_BLK8_BASE;
      end
      if (hi_if.value[1]) begin
         tgt = 4'h9;
         base = `FESRO_BLK9_BASE;
      end
   end

   // ****************************************
   // Overlay mapping and protection
   // ****************************************
   logic ovl_on;
   logic [1:0] area;
   logic [23:0] win_base;
   logic in_win;
   assign ovl_on = ovl_q[`FESRO_OVL_SEL];
   assign area = ovl_q[`FESRO_OVL_AREA_HI:`FESRO_OVL_AREA_LO];
   assign win_base = 24'(`FESRO_SMALL_BASE + 24'(area) * `FESRO_SMALL_STEP);
   assign in_win = cpu_addr >= win_base && cpu_addr < 24'(win_base + `FESRO_SMALL_STEP);

   logic [23:0] faddr_q;
   logic [23:0] faddr_d;
   logic hit_q;
   logic hit_d;
   logic [3:0] tgt_q;
   logic [23:0] base_q;
   logic pmode_q;
   logic pmode_d;
   logic emode_q;
   logic emode_d;
   logic prot_q;

   always_comb begin
      hit_d = ovl_on && in_win;
      faddr_d = hit_d ? (`FESRO_WIN_BASE | (cpu_addr - win_base)) : cpu_addr;
      pmode_d = !ovl_on && ctrl_q[`FESRO_CTRL_WR_ENABLE]
         && ctrl_q[`FESRO_CTRL_PSU] && ctrl_q[`FESRO_CTRL_PROG];
      emode_d = !ovl_on && ctrl_q[`FESRO_CTRL_WR_ENABLE]
         && ctrl_q[`FESRO_CTRL_ESU] && ctrl_q[`FESRO_CTRL_ERASE];
   end

   always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         faddr_q <= 24'h0;
         hit_q <= 1'b0;
         tgt_q <= `FESRO_NO_BLOCK;
         base_q <= 24'h0;
         pmode_q <= 1'b0;
         emode_q <= 1'b0;
         prot_q <= 1'b0;
      end else begin
         faddr_q <= faddr_d;
         hit_q <= hit_d;
         tgt_q <= tgt;
         base_q <= base;
         pmode_q <= pmode_d;
         emode_q <= emode_d;
         prot_q <= ovl_on;
      end
   end

   assign flash_addr = faddr_q;
   assign overlay_hit = hit_q;
   assign erase_target = tgt_q;
   assign erase_base = base_q;
   assign program_mode = pmode_q;
   assign erase_mode = emode_q;
   assign block_protect = prot_q;
endmodule
`default_nettype wire

// [hdl/fesro_cfg.svh]
`ifndef FESRO_CFG_SVH
`define FESRO_CFG_SVH
// Behaviour
// - Low select register reads zero while software write enable is clear.
// - A write to low select leaving several bits set clears it fully.
// - High select register reads zero while software write enable is clear.
// - A write to high select leaving several bits set clears it fully.
// - Low select bits 7..4 target the four large low flash blocks.
// - Low select bits 3..0 target the four 1-kbyte blocks from address zero.
// - High select bits 1..0 target the two 32-kbyte upper blocks.
// - Reserved high select bits 7..2 and overlay bits 7..6 read zero.
// - Overlay select set maps RAM over flash and protects every block.
// - Overlay bits 2..1 choose which 1-kbyte block the RAM window covers.
// - Overlay active keeps program and erase bits from entering their modes.
// - Write enable clear blocks setting any bit of either select register.

// ****************************************
// Register word offsets
// ****************************************
`define FESRO_OFS_CTRL 4'h0
`define FESRO_OFS_SEL_LO 4'h1
`define FESRO_OFS_SEL_HI 4'h2
`define FESRO_OFS_OVL 4'h3

// ****************************************
// Field positions and masks
// ****************************************
`define FESRO_CTRL_WR_ENABLE 6
`define FESRO_CTRL_ESU 5
`define FESRO_CTRL_PSU 4
`define FESRO_CTRL_ERASE 1
`define FESRO_CTRL_PROG 0
`define FESRO_CTRL_MASK 8'h73
`define FESRO_HI_MASK 8'h03
`define FESRO_OVL_MASK 8'h3f
`define FESRO_OVL_SEL 3
`define FESRO_OVL_AREA_HI 2
`define FESRO_OVL_AREA_LO 1
`define FESRO_RST_BYTE 8'h00

// ****************************************
// Address map of flash and RAM window
// ****************************************
`define FESRO_WIN_BASE 24'hffe000
`define FESRO_WIN_LAST 24'hffe3ff
`define FESRO_SMALL_BASE 24'h000000
`define FESRO_SMALL_STEP 24'h000400
`define FESRO_BLK4_BASE 24'h001000
`define FESRO_BLK5_BASE 24'h008000
`define FESRO_BLK6_BASE 24'h00c000
`define FESRO_BLK7_BASE 24'h00e000
`define FESRO_BLK8_BASE 24'h010000
`define FESRO_BLK9_BASE 24'h018000
`define FESRO_FLASH_LAST 24'h01ffff
`define FESRO_NO_BLOCK 4'hf
`endif

// [hdl/fesro_pkg.sv]
`default_nettype none
package fesro_pkg;
   typedef enum logic [1:0] {
      FESRO_IDLE = 2'b00,
      FESRO_ACK = 2'b01
   } fesro_bus_st_t;
   typedef logic [7:0] fesro_byte_t;
endpackage
`default_nettype wire

// [hdl/fesro_sel_if.sv]
`default_nettype none
interface fesro_sel_if;
   logic wr;
   logic [7:0] wdata;
   logic software_write_enable;
   logic [7:0] value;
   modport owner (input wr, input wdata, input software_write_enable, output value);
   modport user (output wr, output wdata, output software_write_enable, input value);
endinterface
`default_nettype wire

// [hdl/fesro_sel_reg.sv]
`include "fesro_cfg.svh"
`default_nettype none
module fesro_sel_reg
   import fesro_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hff
) (
   input wire logic clk,
   input wire logic rst_n,
   fesro_sel_if.owner sel
);
   logic [7:0] val_q;
   logic [7:0] val_d;
   logic [7:0] masked;
   always_comb begin
      masked = sel.wdata & MASK;
      val_d = val_q;
      if (!sel.software_write_enable) begin
         val_d = `FESRO_RST_BYTE;
      end else if (sel.wr) begin
         if ($countones(masked) > 1) begin
            val_d = `FESRO_RST_BYTE;
         end else begin
            val_d = masked;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         val_q <= `FESRO_RST_BYTE;
      end else begin
         val_q <= val_d;
      end
   end
   assign sel.value = val_q;
endmodule
`default_nettype wire

// [verif/fesro_assertions.sv]
`default_nettype none
// ***
// Checker on top ports
// ***
module fesro_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [23:0] cpu_addr,
   input wire logic [23:0] flash_addr,
   input wire logic overlay_hit,
   input wire logic [3:0] erase_target,
   input wire logic [23:0] erase_base,
   input wire logic program_mode,
   input wire logic erase_mode,
   input wire logic block_protect
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer after one wait state");
   a_hi_rsvd: assert property (avs_read && avs_address == 4'h2 && !avs_waitrequest |->
      avs_readdata[31:2] == 30'h0)
      else $error("high select reserved bits set");
   a_ovl_rsvd: assert property (avs_read && avs_address == 4'h3 && !avs_waitrequest |->
      avs_readdata[31:6] == 26'h0)
      else $error("overlay reserved bits set");
   a_prot_modes: assert property (block_protect && $past(block_protect) |-> !program_mode && !erase_mode)
      else $error("mode entered while protected");
   a_small_base: assert property (erase_target < 4'h4 |-> erase_base == {12'h0, erase_target[1:0], 10'h0})
      else $error("small block base wrong");
   a_large_base: assert property (erase_target[3:2] == 2'b01 |-> erase_base == (erase_target[1] ?
      (erase_target[0] ? 24'h00e000 : 24'h00c000) : (erase_target[0] ? 24'h008000 : 24'h001000)))
      else $error("large block base wrong");
   a_high_base: assert property (erase_target[3:1] == 3'b100 |->
      erase_base == (erase_target[0] ? 24'h018000 : 24'h010000))
      else $error("high block base wrong");
   a_win_map: assert property (overlay_hit |-> flash_addr == {14'h3ff8, $past(cpu_addr[9:0])} &&
      $past(cpu_addr[23:12]) == 12'h0 && block_protect)
      else $error("overlay window mapping wrong");
   a_reset_clr: assert property ($rose(rst_n) |-> erase_target == 4'hf && !block_protect && !overlay_hit)
      else $error("state not cleared by reset");
endmodule
bind fesro_top fesro_assertions u_chk (.*);
`default_nettype wire

// [verif/tb.sv]
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   logic [3:0] avs_address = 0, erase_target;
   logic [31:0] avs_writedata = 0, avs_readdata, q;
   logic [23:0] cpu_addr = 0, flash_addr, erase_base;
   logic avs_waitrequest, overlay_hit, program_mode, erase_mode, block_protect;
   int errors = 0, total_checks = 0, cyc = 0, a, h, m[4];
   int base[10] = '{0, 'h400, 'h800, 'hc00, 'h1000, 'h8000, 'hc000, 'he000, 'h10000, 'h18000};
   fesro_top DUT (.*);
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         report_and_stop();
      end
   end
   // ***
   // Model and helpers
   // ***
   task report_and_stop;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s exp %h seen %h", what, exp, seen);
      end
   endtask
   function void mw(int r, int d);
      int k;
      k = (r == 1) ? 'hff : 3;
      if (r == 0) m[0] = d[6] ? d & 'h73 : 0;
      if (r == 1 || r == 2) m[r] = (m[0][6] && $countones(d & k) < 2) ? d & k : 0;
      if (r == 3) m[3] = d & 'h3f;
      if (!m[0][6]) m[1] = 0;
      if (!m[0][6]) m[2] = 0;
   endfunction
   task bus(input bit w, input int r, input int d);
      @(posedge core_clk);
      avs_address <= r[3:0];
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
   endtask
   task co;
      int b, t;
      @(negedge core_clk);
      b = m[2] * 256 + m[1];
      t = 15;
      for (int i = 0; i < 10; i++) if (b[i]) t = i;
      if ($countones(b) < 2) chk(erase_target, t, "target");
      if (t < 15 && $countones(b) < 2) chk(erase_base, base[t], "base");
      chk(block_protect, m[3][3], "protect");
      chk(program_mode, m[0][6] & m[0][4] & m[0][0] & !m[3][3], "prog");
      chk(erase_mode, m[0][6] & m[0][5] & m[0][1] & !m[3][3], "erase");
   endtask
   task wr(input int r, input int d);
      bus(1, r, d);
      mw(r, d);
      repeat (2) @(posedge core_clk);
      co();
   endtask
   task rd(input int r);
      bus(0, r, 0);
      chk(q, r < 4 ? m[r] : 0, "readback");
   endtask
   task rst;
      @(posedge core_clk) rst_n <= 0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1;
      m = '{0, 0, 0, 0};
      repeat (3) @(posedge core_clk);
      for (int r = 0; r < 6; r++) rd(r);
      co();
   endtask
   // ***
   // Scenarios
   // ***
   initial begin
      void'($urandom(72892));
      rst();
      wr(1, 1);
      wr(2, 1);
      rd(1);
      rd(2);
      wr(0, 'h40);
      for (int i = 0; i < 10; i++) begin
         wr(1, i < 8 ? 1 << i : 0);
         wr(2, i < 8 ? 0 : 1 << (i - 8));
         rd(1);
         rd(2);
      end
      wr(2, 'hff);
      rd(2);
      wr(1, 'h03);
      rd(1);
      repeat (12) begin
         wr(1 + $urandom % 2, ($urandom % 3 == 0) ? $urandom % 256 : 1 << ($urandom % 8));
         rd(1);
         rd(2);
      end
      wr(0, 0);
      rd(1);
      rd(2);
      wr(7, 'hff);
      rd(7);
      for (int k = 0; k < 5; k++) begin
         wr(3, k < 4 ? 'hc8 + 2 * k + $urandom % 2 : 6);
         rd(3);
         repeat (6) begin
            a = $urandom % 'h1400;
            @(posedge core_clk) cpu_addr <= a[23:0];
            @(posedge core_clk);
            @(negedge core_clk);
            h = (k < 4 && a < 'h1000 && a[11:10] == k);
            chk(overlay_hit, h, "hit");
            chk(flash_addr, h ? 'hffe000 + a % 1024 : a, "faddr");
         end
      end
      wr(0, 'h51);
      wr(0, 'h62);
      wr(3, 8);
      wr(0, 'h51);
      wr(0, 'h62);
      wr(3, 0);
      wr(1, 'h10);
      rst();
      report_and_stop();
   end
endmodule
`default_nettype wire
